/* File: hdl/qch_top.sv */
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
`include "qch_cfg.svh"
// Contract
// - Access the device only with select low; read strobe reads, write strobe writes.
// - Control/data select high picks setup/status, low picks load value/snapshot.
// - Load value goes as three data writes, low byte first, then middle, high.
// - To read count, command count-to-snapshot, then three reads low to high.
// - Direction-type levels from the driver change only while A is high.
// - Gate level from the driver changes only while A is high.
module qch_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [7:0] dev_data_i,
   output logic [7:0] dev_data_o,
   output logic dev_data_oe,
   output logic dev_cs_n,
   output logic dev_rd_n,
   output logic dev_wr_n,
   output logic dev_cd,
   input wire logic count_a_pin,
   input wire logic carry_pin,
   input wire logic borrow_pin,
   output logic gate_or_clear_n,
   output logic load_strobe_n
);
   localparam int NS = `QCH_MAX_STEPS;
   localparam logic [1:0] C_LOAD = 2'(`QCH_CYC(`QCH_T_LOAD_NS));

   qch_bus_if bus ();

   ////////////////////////////////////////////////////////////////////////////////
   // Pin input synchronisers
   logic [10:0] sy_q, sy_ok;

   qch_sync #(.W(11)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .d({borrow_pin, carry_pin, count_a_pin, dev_data_i}),
      .q(sy_q),
      .stable(sy_ok)
   );

   assign bus.din = sy_q[7:0];
   assign bus.din_ok = &sy_ok[7:0];

   logic a_high, carry_now, borrow_now;
   assign a_high = sy_q[8] && sy_ok[8];
   assign carry_now = sy_q[9];
   assign borrow_now = sy_q[10];

   qch_pin_seq u_seq (
      .hclk(hclk),
      .hresetn(hresetn),
      .bus(bus.seq),
      .dev_cs_n(dev_cs_n),
      .dev_rd_n(dev_rd_n),
      .dev_wr_n(dev_wr_n),
      .dev_cd(dev_cd),
      .dev_data_o(dev_data_o),
      .dev_data_oe(dev_data_oe)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states
   logic dp_valid_r, dp_valid_nxt, dp_write_r, dp_write_nxt;
   logic [7:0] dp_addr_r, dp_addr_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic hreadyout_r, hresp_r;
   logic ap_take;
   logic [31:0] rd_mux;

   assign ap_take = hsel && htrans[1] && hready;

   // Engine and register state
   qch_pkg::qch_eng_e eng_r, eng_nxt;
   qch_pkg::qch_step_s steps_r [NS];
   qch_pkg::qch_step_s steps_nxt [NS];
   logic [2:0] n_r, n_nxt, idx_r, idx_nxt;
   logic snap_mode_r, snap_mode_nxt, req_r, req_nxt;
   logic [23:0] snap_r, snap_nxt, preset_r, preset_nxt;
   logic [7:0] rbyte_r, rbyte_nxt;
   logic refused_r, refused_nxt;
   logic gate_want_r, gate_want_nxt, gate_r, gate_nxt;
   logic load_n_r, load_n_nxt;
   logic [1:0] load_cnt_r, load_cnt_nxt;
   logic busy;
   logic wr_go, go_acc, go_pre, go_snap, launch;

   assign busy = (eng_r != qch_pkg::EN_IDLE);
   assign wr_go = dp_valid_r && dp_write_r;
   assign go_acc = wr_go && (dp_addr_r == `QCH_OFF_ACCESS);
   assign go_pre = wr_go && (dp_addr_r == `QCH_OFF_PRESET);
   assign go_snap = wr_go && (dp_addr_r == `QCH_OFF_SNAP);
   assign launch = (go_acc || go_pre || go_snap) && !busy;

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (haddr[7:0])
         `QCH_OFF_PRESET: rd_mux = {8'h00, preset_r};
         `QCH_OFF_SNAP: rd_mux = {8'h00, snap_r};
         `QCH_OFF_STATUS: begin
            rd_mux[`QCH_ST_BUSY_BIT] = busy;
            rd_mux[`QCH_ST_REFUSED_BIT] = refused_r;
            rd_mux[`QCH_ST_CARRY_BIT] = carry_now;
            rd_mux[`QCH_ST_BORROW_BIT] = borrow_now;
            rd_mux[`QCH_ST_RBYTE_LSB +: 8] = rbyte_r;
         end
         `QCH_OFF_PINS: rd_mux[`QCH_PIN_GATE_BIT] = gate_want_r;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      dp_valid_nxt = ap_take;
      dp_write_nxt = ap_take && hwrite;
      dp_addr_nxt = ap_take ? {haddr[7:2], 2'b00} : dp_addr_r;
      hrdata_nxt = (ap_take && !hwrite) ? rd_mux : 32'h0000_0000;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid_r <= 1'b0;
         dp_write_r <= 1'b0;
         dp_addr_r <= 8'h00;
         hrdata_r <= 32'h0000_0000;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end else begin
         dp_valid_r <= dp_valid_nxt;
         dp_write_r <= dp_write_nxt;
         dp_addr_r <= dp_addr_nxt;
         hrdata_r <= hrdata_nxt;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end
   end

   assign hreadyout = hreadyout_r;
   assign hrdata = hrdata_r;
   assign hresp = hresp_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Command engine: a list of device accesses
   always_comb begin
      eng_nxt = eng_r;
      steps_nxt = steps_r;
      n_nxt = n_r;
      idx_nxt = idx_r;
      snap_mode_nxt = snap_mode_r;
      req_nxt = 1'b0;
      snap_nxt = snap_r;
      preset_nxt = preset_r;
      rbyte_nxt = rbyte_r;
      refused_nxt = refused_r;
      if (wr_go && (dp_addr_r == `QCH_OFF_STATUS) && hwdata[`QCH_ST_REFUSED_BIT]) begin
         refused_nxt = 1'b0;
      end
      if ((go_acc || go_pre || go_snap) && busy) begin
         refused_nxt = 1'b1;
      end
      unique case (eng_r)
         qch_pkg::EN_IDLE: begin
            if (launch) begin
               eng_nxt = qch_pkg::EN_RUN;
               idx_nxt = 3'h0;
               snap_mode_nxt = go_snap;
               if (go_acc) begin
                  steps_nxt[0] = {hwdata[`QCH_ACC_RD_BIT], hwdata[`QCH_ACC_CD_BIT],
                                  hwdata[7:0]};
                  n_nxt = 3'h1;
               end else if (go_pre) begin
                  preset_nxt = hwdata[23:0];
                  steps_nxt[0] = {1'b0, 1'b1, `QCH_MCR_RST_BP};
                  for (int i = 0; i < 3; i++) begin
                     steps_nxt[i+1] = {1'b0, 1'b0, hwdata[8*i +: 8]};
                  end
                  steps_nxt[4] = {1'b0, 1'b1, `QCH_MCR_LOAD_CNT};
                  n_nxt = hwdata[`QCH_PRE_LOAD_BIT] ? `QCH_PRE_LOAD_STEPS : `QCH_PRE_STEPS;
               end else begin
                  steps_nxt[0] = {1'b0, 1'b1, `QCH_MCR_BP_SNAP};
                  for (int i = 1; i < 4; i++) begin
                     steps_nxt[i] = {1'b1, 1'b0, 8'h00};
                  end
                  n_nxt = `QCH_SNAP_STEPS;
               end
            end
         end
         qch_pkg::EN_RUN: begin
            req_nxt = 1'b1;
            eng_nxt = qch_pkg::EN_WAIT;
         end
         qch_pkg::EN_WAIT: begin
            if (bus.done) begin
               if (steps_r[idx_r].rd) begin
                  rbyte_nxt = bus.rdata;
                  for (int i = 0; i < 3; i++) begin
                     if (snap_mode_r && (idx_r == 3'(i + 1))) begin
                        snap_nxt[8*i +: 8] = bus.rdata;
                     end
                  end
               end
               idx_nxt = idx_r + 3'h1;
               eng_nxt = ((idx_r + 3'h1) == n_r) ? qch_pkg::EN_IDLE : qch_pkg::EN_RUN;
            end
         end
         default: eng_nxt = qch_pkg::EN_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         eng_r <= qch_pkg::EN_IDLE;
         for (int i = 0; i < NS; i++) begin
            steps_r[i] <= '0;
         end
         n_r <= 3'h0;
         idx_r <= 3'h0;
         snap_mode_r <= 1'b0;
         req_r <= 1'b0;
         snap_r <= 24'h00_0000;
         preset_r <= 24'h00_0000;
         rbyte_r <= 8'h00;
         refused_r <= 1'b0;
      end else begin
         eng_r <= eng_nxt;
         steps_r <= steps_nxt;
         n_r <= n_nxt;
         idx_r <= idx_nxt;
         snap_mode_r <= snap_mode_nxt;
         req_r <= req_nxt;
         snap_r <= snap_nxt;
         preset_r <= preset_nxt;
         rbyte_r <= rbyte_nxt;
         refused_r <= refused_nxt;
      end
   end

   assign bus.req = req_r;
   assign bus.step = steps_r[idx_r];

   ////////////////////////////////////////////////////////////////////////////////
   // Gate level and load strobe pins
   always_comb begin
      gate_want_nxt = gate_want_r;
      gate_nxt = gate_r;
      load_cnt_nxt = load_cnt_r;
      load_n_nxt = load_n_r;
      if (wr_go && (dp_addr_r == `QCH_OFF_PINS)) begin
         gate_want_nxt = hwdata[`QCH_PIN_GATE_BIT];
         if (hwdata[`QCH_PIN_LOAD_BIT] && load_n_r) begin
            load_cnt_nxt = C_LOAD;
         end
      end
      if ((gate_want_r != gate_r) && a_high) begin
         gate_nxt = gate_want_r;
      end
      if (load_cnt_r != 2'h0) begin
         load_cnt_nxt = load_cnt_r - 2'h1;
         load_n_nxt = 1'b0;
      end else begin
         load_n_nxt = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_want_r <= 1'b1;
         gate_r <= 1'b1;
         load_cnt_r <= 2'h0;
         load_n_r <= 1'b1;
      end else begin
         gate_want_r <= gate_want_nxt;
         gate_r <= gate_nxt;
         load_cnt_r <= load_cnt_nxt;
         load_n_r <= load_n_nxt;
      end
   end

   assign gate_or_clear_n = gate_r;
   assign load_strobe_n = load_n_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_SNAP_CMD: assert property (@(posedge hclk) disable iff (!hresetn)
      (launch && go_snap) |=> (steps_r[0].data == `QCH_MCR_BP_SNAP && steps_r[0].cd
                               && steps_r[1].rd && steps_r[3].rd && n_r == 3'h4))
      else $error("Snapshot sequence built wrong");
   AST_PRESET_ORDER: assert property (@(posedge hclk) disable iff (!hresetn)
      (launch && go_pre) |=> (steps_r[1].data == $past(hwdata[7:0])
                              && steps_r[3].data == $past(hwdata[23:16])
                              && !steps_r[1].cd && steps_r[0].data == `QCH_MCR_RST_BP))
      else $error("Load value bytes out of order");
   AST_SNAP_FILL: assert property (@(posedge hclk) disable iff (!hresetn)
      (eng_r == qch_pkg::EN_WAIT && bus.done && snap_mode_r && idx_r == 3'h1)
      |=> snap_r[7:0] == $past(bus.rdata))
      else $error("First snapshot read not stored as low byte");
   AST_GATE_A_HIGH: assert property (@(posedge hclk) disable iff (!hresetn)
      (gate_r != $past(gate_r)) |-> $past(a_high))
      else $error("Gate changed while A low");
   AST_ACCESS_BOUND: assert property (@(posedge hclk) disable iff (!hresetn)
      (req_r && !bus.step.rd) |-> ##[8:12] bus.done)
      else $error("Write access did not finish in time");
   COV_PRESET_LOAD: cover property (@(posedge hclk) disable iff (!hresetn)
      launch && go_pre && hwdata[`QCH_PRE_LOAD_BIT]);
   COV_SNAP_DONE: cover property (@(posedge hclk) disable iff (!hresetn)
      snap_mode_r && $fell(busy));
   COV_REFUSED: cover property (@(posedge hclk) disable iff (!hresetn) $rose(refused_r));
endmodule : qch_top

/* File: inc/qch_cfg.svh */
`ifndef QCH_CFG_SVH
`define QCH_CFG_SVH

// Clock and pin timing
`define QCH_CLK_NS 40
`define QCH_T_CSSU_NS 60
`define QCH_T_WR_NS 60
`define QCH_T_RD_NS 110
`define QCH_T_HOLD_NS 30
`define QCH_T_GAP_NS 60
`define QCH_T_LOAD_NS 60
`define QCH_CYC(t) (((t) + `QCH_CLK_NS - 1) / `QCH_CLK_NS)
`define QCH_SYNC_DEPTH 3

// Register offsets
`define QCH_OFF_ACCESS 8'h00
`define QCH_OFF_PRESET 8'h04
`define QCH_OFF_SNAP 8'h08
`define QCH_OFF_STATUS 8'h0c
`define QCH_OFF_PINS 8'h10

// Field positions
`define QCH_ACC_CD_BIT 8
`define QCH_ACC_RD_BIT 9
`define QCH_PRE_LOAD_BIT 24
`define QCH_ST_BUSY_BIT 0
`define QCH_ST_REFUSED_BIT 1
`define QCH_ST_CARRY_BIT 2
`define QCH_ST_BORROW_BIT 3
`define QCH_ST_RBYTE_LSB 8
`define QCH_PIN_GATE_BIT 0
`define QCH_PIN_LOAD_BIT 1

// Device command words
`define QCH_MCR_RST_BP 8'h01
`define QCH_MCR_BP_SNAP 8'h03
`define QCH_MCR_LOAD_CNT 8'h08

// Engine sizes
`define QCH_MAX_STEPS 5
`define QCH_PRE_STEPS 3'h4
`define QCH_PRE_LOAD_STEPS 3'h5
`define QCH_SNAP_STEPS 3'h4

`endif

/* File: inc/qch_pkg.sv */
package qch_pkg;

   typedef struct packed {
      logic rd;
      logic cd;
      logic [7:0] data;
   } qch_step_s;

   typedef enum logic [4:0] {
      SQ_IDLE = 5'b00001,
      SQ_SETUP = 5'b00010,
      SQ_STRB = 5'b00100,
      SQ_HOLD = 5'b01000,
      SQ_GAP = 5'b10000
   } qch_seq_e;

   typedef enum logic [2:0] {
      EN_IDLE = 3'b001,
      EN_RUN = 3'b010,
      EN_WAIT = 3'b100
   } qch_eng_e;

endpackage : qch_pkg

/* File: inc/qch_bus_if.sv */
`timescale 1ns/1ns
interface qch_bus_if;
   logic req;
   qch_pkg::qch_step_s step;
   logic done;
   logic [7:0] rdata;
   logic [7:0] din;
   logic din_ok;
   modport ctl (output req, output step, output din, output din_ok, input done, input rdata);
   modport seq (input req, input step, input din, input din_ok, output done, output rdata);
endinterface : qch_bus_if

/* File: hdl/qch_sync.sv */
`timescale 1ns/1ns
module qch_sync #(
   parameter int W = 1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q,
   output logic [W-1:0] stable
);
   logic [W-1:0] s1_r, s2_r, s3_r;
   logic [W-1:0] s1_nxt, s2_nxt, s3_nxt;

   always_comb begin
      s1_nxt = d;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s2_nxt;
         s3_r <= s3_nxt;
      end
   end

   assign q = s3_r;
   assign stable = ~(s2_r ^ s3_r);
endmodule : qch_sync

/* File: hdl/qch_pin_seq.sv */
`timescale 1ns/1ns
`include "qch_cfg.svh"
module qch_pin_seq (
   input wire logic hclk,
   input wire logic hresetn,
   qch_bus_if.seq bus,
   output logic dev_cs_n,
   output logic dev_rd_n,
   output logic dev_wr_n,
   output logic dev_cd,
   output logic [7:0] dev_data_o,
   output logic dev_data_oe
);
   localparam logic [3:0] C_SU = 4'(`QCH_CYC(`QCH_T_CSSU_NS) - 1);
   localparam logic [3:0] C_WR = 4'(`QCH_CYC(`QCH_T_WR_NS) - 1);
   localparam logic [3:0] C_RD = 4'(`QCH_CYC(`QCH_T_RD_NS) + `QCH_SYNC_DEPTH - 1);
   localparam logic [3:0] C_HOLD = 4'(`QCH_CYC(`QCH_T_HOLD_NS) - 1);
   localparam logic [3:0] C_GAP = 4'(`QCH_CYC(`QCH_T_GAP_NS) - 1);

   qch_pkg::qch_seq_e st_r, st_nxt;
   qch_pkg::qch_step_s step_r, step_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic cs_n_r, cs_n_nxt, rd_n_r, rd_n_nxt, wr_n_r, wr_n_nxt, cd_r, cd_nxt;
   logic oe_r, oe_nxt, done_r, done_nxt;
   logic [7:0] dout_r, dout_nxt, rdata_r, rdata_nxt;

   ////////////////////////////////////////////////////////////////////////////////
   // One device bus cycle
   always_comb begin
      st_nxt = st_r;
      step_nxt = step_r;
      cnt_nxt = cnt_r;
      cs_n_nxt = cs_n_r;
      rd_n_nxt = rd_n_r;
      wr_n_nxt = wr_n_r;
      cd_nxt = cd_r;
      oe_nxt = oe_r;
      dout_nxt = dout_r;
      rdata_nxt = rdata_r;
      done_nxt = 1'b0;
      unique case (st_r)
         qch_pkg::SQ_IDLE: begin
            if (bus.req) begin
               step_nxt = bus.step;
               st_nxt = qch_pkg::SQ_SETUP;
               cnt_nxt = C_SU;
               cs_n_nxt = 1'b0;
               cd_nxt = bus.step.cd;
               oe_nxt = !bus.step.rd;
               dout_nxt = bus.step.data;
            end
         end
         qch_pkg::SQ_SETUP: begin
            if (cnt_r != 4'h0) begin
               cnt_nxt = cnt_r - 4'h1;
            end else begin
               st_nxt = qch_pkg::SQ_STRB;
               if (step_r.rd) begin
                  rd_n_nxt = 1'b0;
                  cnt_nxt = C_RD;
               end else begin
                  wr_n_nxt = 1'b0;
                  cnt_nxt = C_WR;
               end
            end
         end
         qch_pkg::SQ_STRB: begin
            if (cnt_r != 4'h0) begin
               cnt_nxt = cnt_r - 4'h1;
            end else if (!step_r.rd || bus.din_ok) begin
               rd_n_nxt = 1'b1;
               wr_n_nxt = 1'b1;
               if (step_r.rd) begin
                  rdata_nxt = bus.din;
               end
               st_nxt = qch_pkg::SQ_HOLD;
               cnt_nxt = C_HOLD;
            end
         end
         qch_pkg::SQ_HOLD: begin
            if (cnt_r != 4'h0) begin
               cnt_nxt = cnt_r - 4'h1;
            end else begin
               cs_n_nxt = 1'b1;
               oe_nxt = 1'b0;
               st_nxt = qch_pkg::SQ_GAP;
               cnt_nxt = C_GAP;
            end
         end
         qch_pkg::SQ_GAP: begin
            if (cnt_r != 4'h0) begin
               cnt_nxt = cnt_r - 4'h1;
            end else begin
               done_nxt = 1'b1;
               st_nxt = qch_pkg::SQ_IDLE;
            end
         end
         default: begin
            st_nxt = qch_pkg::SQ_IDLE;
            cs_n_nxt = 1'b1;
            rd_n_nxt = 1'b1;
            wr_n_nxt = 1'b1;
            oe_nxt = 1'b0;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= qch_pkg::SQ_IDLE;
         step_r <= '0;
         cnt_r <= 4'h0;
         cs_n_r <= 1'b1;
         rd_n_r <= 1'b1;
         wr_n_r <= 1'b1;
         cd_r <= 1'b0;
         oe_r <= 1'b0;
         dout_r <= 8'h00;
         rdata_r <= 8'h00;
         done_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         step_r <= step_nxt;
         cnt_r <= cnt_nxt;
         cs_n_r <= cs_n_nxt;
         rd_n_r <= rd_n_nxt;
         wr_n_r <= wr_n_nxt;
         cd_r <= cd_nxt;
         oe_r <= oe_nxt;
         dout_r <= dout_nxt;
         rdata_r <= rdata_nxt;
         done_r <= done_nxt;
      end
   end

   assign dev_cs_n = cs_n_r;
   assign dev_rd_n = rd_n_r;
   assign dev_wr_n = wr_n_r;
   assign dev_cd = cd_r;
   assign dev_data_o = dout_r;
   assign dev_data_oe = oe_r;
   assign bus.done = done_r;
   assign bus.rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_STROBE_NEEDS_CS: assert property (@(posedge hclk) disable iff (!hresetn)
      (!rd_n_r || !wr_n_r) |-> (!cs_n_r && !(!rd_n_r && !wr_n_r)))
      else $error("Strobe without select or both strobes low");
   AST_CD_STABLE: assert property (@(posedge hclk) disable iff (!hresetn)
      (!cs_n_r && !$past(cs_n_r)) |-> $stable(cd_r))
      else $error("Control/data select moved inside an access");
   AST_WR_WIDTH: assert property (@(posedge hclk) disable iff (!hresetn)
      $fell(wr_n_r) |-> (!wr_n_r) [*2] ##1 wr_n_r)
      else $error("Write strobe width wrong");
   AST_WR_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(wr_n_r) |-> (oe_r && !cs_n_r && $stable(dout_r) && $stable(cd_r)))
      else $error("Data not held over write strobe rise");
   AST_NO_DRIVE_ON_READ: assert property (@(posedge hclk) disable iff (!hresetn)
      !rd_n_r |-> !oe_r)
      else $error("Host drives bus during read");
   COV_WRITE: cover property (@(posedge hclk) disable iff (!hresetn) $rose(wr_n_r));
   COV_READ: cover property (@(posedge hclk) disable iff (!hresetn) $rose(rd_n_r));
endmodule : qch_pin_seq

/* File: test/qch_dev_model.sv */
`timescale 1ns/1ns
module qch_dev_model (
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic cd,
   input wire logic [7:0] din,
   input wire logic a_in,
   input wire logic b_in,
   input wire logic gate_n,
   input wire logic load_n,
   output logic [7:0] dout,
   output logic comp_n
);
   logic [23:0] pr = 24'h0;
   logic [23:0] cnt = 24'h0;
   logic [23:0] ol = 24'h0;
   logic [5:0] input_setup_reg = 6'h0;
   logic [5:0] output_setup_reg = 6'h0;
   logic [1:0] qr = 2'h0;
   logic [1:0] bp = 2'h0;
   localparam logic [23:0] PR_SET = 24'hff_ffff;
   logic [7:0] last = 8'h0;
   logic hush = 1'b0;
   logic [7:0] cur;
   assign cur = cd ? {7'h0, cnt == pr} : ol[bp*8 +: 8];
   assign dout = (!cs_n && !rd_n) ? cur : ~last;
   assign comp_n = ~((cnt == pr) && !hush);
   always @(posedge wr_n) if (!cs_n) begin
      if (!cd) begin
         pr[bp*8 +: 8] = din;
         bp = (bp == 2'h2) ? 2'h0 : bp + 2'h1;
      end else case (din[7:6])
         2'h0: begin
            if (din[5]) begin
               cnt = 24'h0;
               input_setup_reg = 6'h0;
               output_setup_reg = 6'h0;
               qr = 2'h0;
               ol = 24'h0;
               bp = 2'h0;
               pr = PR_SET;
            end
            if (din[1]) ol = cnt;
            if (din[0]) bp = 2'h0;
            if (din[3]) begin
               cnt = pr;
               hush = 1'b1;
            end
         end
         2'h1: input_setup_reg = din[5:0];
         2'h2: output_setup_reg = din[5:0];
         default: qr = din[1:0];
      endcase
   end
   always @(posedge rd_n) if (!cs_n) begin
      last = cur;
      if (!cd) bp = (bp == 2'h2) ? 2'h0 : bp + 2'h1;
   end
   always @(posedge a_in) if (gate_n || !input_setup_reg[4]) begin
      cnt = (input_setup_reg[0] && b_in) ? cnt - 24'h1 : cnt + 24'h1;
      hush = 1'b0;
   end
   always @(posedge b_in) if (!input_setup_reg[0] && (gate_n || !input_setup_reg[4])) begin
      cnt = cnt - 24'h1;
      hush = 1'b0;
   end
   always @(negedge gate_n) if (!input_setup_reg[4]) cnt = 24'h0;
   always @(negedge load_n) begin
      if (input_setup_reg[5]) ol = cnt;
      else begin
         cnt = pr;
         hush = 1'b1;
      end
   end
endmodule : qch_dev_model

/* File: test/quadrature_counter_24bit_tb.sv */
`timescale 1ns/1ns
module quadrature_counter_24bit_tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hreadyout, hresp, oe, cs_n, rd_n, wr_n, cd, gate_n, load_n, comp_n;
   logic [31:0] hrdata, q;
   logic [7:0] data_o, bus, dout;
   logic a = 1'b0;
   int error_cnt = 0;
   int num_checks = 0;
   int cyc = 0;
   assign bus = oe ? data_o : dout;
   qch_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .dev_data_i(bus), .dev_data_o(data_o), .dev_data_oe(oe),
      .dev_cs_n(cs_n), .dev_rd_n(rd_n), .dev_wr_n(wr_n), .dev_cd(cd), .count_a_pin(a),
      .carry_pin(comp_n), .borrow_pin(1'b1), .gate_or_clear_n(gate_n), .load_strobe_n(load_n));
   qch_dev_model u_dev (.cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .cd(cd), .din(bus), .a_in(a),
      .b_in(1'b1), .gate_n(gate_n), .load_n(load_n), .dout(dout), .comp_n(comp_n));
   initial forever #20 hclk = ~hclk;
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : check
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, ad};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
      check("hresp", hresp, 32'h0);
   endtask : ahb
   task automatic idle;
      repeat (2) @(posedge hclk);
      for (int i = 0; i < 200; i++) begin
         ahb(1'b0, 8'h0c, 32'h0);
         if (q[0] === 1'b0) break;
      end
      check("busy", q[0], 32'h0);
   endtask : idle
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         give_verdict();
      end
   end
   initial begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      ahb(1'b0, 8'h10, 32'h0);
      check("pins", q & 32'h1, 32'h1);
      ahb(1'b0, 8'h14, 32'h0);
      check("unmapped", q, 32'h0);
      ahb(1'b1, 8'h04, 32'h0112a5c3);
      idle();
      check("count", u_dev.cnt, 32'h12a5c3);
      ahb(1'b0, 8'h0c, 32'h0);
      check("carry and borrow pins", q & 32'hc, 32'hc);
      repeat (3) begin
         @(posedge hclk) a <= 1'b1;
         @(posedge hclk) a <= 1'b0;
      end
      ahb(1'b1, 8'h08, 32'h0);
      idle();
      ahb(1'b0, 8'h08, 32'h0);
      check("snapshot", q & 32'hffffff, 32'h12a5c6);
      ahb(1'b1, 8'h00, 32'h15a);
      idle();
      check("input setup", u_dev.input_setup_reg, 32'h1a);
      ahb(1'b1, 8'h10, 32'h3);
      repeat (6) @(posedge hclk);
      check("load strobe", u_dev.cnt, 32'h12a5c3);
      ahb(1'b1, 8'h00, 32'h300);
      idle();
      check("status byte", q[15:8], 32'h1);
      ahb(1'b1, 8'h08, 32'h0);
      ahb(1'b1, 8'h08, 32'h0);
      idle();
      check("refused", q[1], 32'h1);
      ahb(1'b1, 8'h0c, 32'h2);
      ahb(1'b0, 8'h0c, 32'h0);
      check("refused clear", q[1], 32'h0);
      ahb(1'b1, 8'h00, 32'h140);
      idle();
      a <= 1'b1;
      ahb(1'b1, 8'h10, 32'h0);
      for (int i = 0; i < 50 && gate_n !== 1'b0; i++) @(posedge hclk);
      #1 check("clear", u_dev.cnt, 32'h0);
      give_verdict();
   end
endmodule : quadrature_counter_24bit_tb
